// >>> shared/mfde_pkg.sv
/*
  mfde_pkg: constants for the module fault diagnostic encoder.
  Assumes a single clock domain; used by the encoder and its bench.
*/
package mfde_pkg;
  localparam int unsigned SELECTOR_BYTE    = 7;
  localparam int unsigned FIRST_ENTRY_BYTE = 16;
  localparam int unsigned LAST_ENTRY_BYTE  = 60;
  localparam int unsigned MAX_ENTRIES      = (LAST_ENTRY_BYTE - FIRST_ENTRY_BYTE) / 2 + 1;
  localparam logic [7:0]  FMT_SMALL        = 8'h81;
  localparam logic [7:0]  FMT_LARGE        = 8'hA1;
  localparam int unsigned FAULT_BIT_STD    = 6;
  localparam int unsigned FAULT_BIT_SERIAL = 3;
  localparam int unsigned SMALL_MOD_MAX    = 63;
  localparam int unsigned CHANNELS         = 4;
  typedef enum logic [1:0] {MFDE_IDLE, MFDE_SCAN, MFDE_DONE} mfde_state_t;
endpackage

// >>> src/mfde_encoder.sv
/*
  mfde_encoder: walks module channel status and emits diagnostic entry bytes.
  Assumes a status source that answers combinationally to o_mod_index/o_chan_index
  within the same cycle, and a byte sink that stores each o_byte_valid pulse.
*/
`timescale 1ns/10ps
module mfde_encoder #(
  parameter int unsigned NUM_MODULES = 64
) (
  input  wire logic       i_clock,
  input  wire logic       i_resetn,
  input  wire logic       i_start,
  input  wire logic       i_diag_enable,
  input  wire logic       i_large_layout,
  input  wire logic [7:0] i_status,
  input  wire logic       i_is_serial,
  output logic      [7:0] o_mod_index,
  output logic      [1:0] o_chan_index,
  output logic            o_byte_valid,
  output logic      [5:0] o_byte_addr,
  output logic      [7:0] o_byte_data,
  output logic      [4:0] o_entry_count,
  output logic            o_done
);
  localparam logic [7:0] LAST_MOD = 8'(NUM_MODULES - 1);
  localparam logic [4:0] MAXE     = 5'(mfde_pkg::MAX_ENTRIES);

  mfde_pkg::mfde_state_t state_r, state_nxt;
  logic [7:0] mod_r, mod_nxt;
  logic [1:0] ch_r, ch_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic       half_r, half_nxt;
  logic       large_r, large_nxt;
  logic       sel_r, sel_nxt;
  logic       vld_r, vld_nxt;
  logic [5:0] addr_r, addr_nxt;
  logic [7:0] data_r, data_nxt;
  logic [7:0] stat_r, stat_nxt;
  logic       done_r, done_nxt;
  logic       faulty;

  function automatic logic is_faulty(input logic [7:0] s, input logic serial);
    return serial ? s[mfde_pkg::FAULT_BIT_SERIAL] : s[mfde_pkg::FAULT_BIT_STD];
  endfunction

  assign faulty = is_faulty(i_status, i_is_serial);

  always_comb begin
    state_nxt = state_r;
    mod_nxt   = mod_r;
    ch_nxt    = ch_r;
    cnt_nxt   = cnt_r;
    half_nxt  = half_r;
    large_nxt = large_r;
    sel_nxt   = sel_r;
    vld_nxt   = 1'b0;
    addr_nxt  = addr_r;
    data_nxt  = data_r;
    stat_nxt  = stat_r;
    done_nxt  = 1'b0;
    unique case (state_r)
      mfde_pkg::MFDE_IDLE: begin
        if (i_start) begin
          large_nxt = i_large_layout;
          mod_nxt   = 8'h00;
          ch_nxt    = 2'h0;
          cnt_nxt   = 5'h00;
          half_nxt  = 1'b0;
          sel_nxt   = 1'b1;
          vld_nxt   = 1'b1;
          addr_nxt  = 6'(mfde_pkg::SELECTOR_BYTE);
          data_nxt  = i_large_layout ? mfde_pkg::FMT_LARGE : mfde_pkg::FMT_SMALL;
          state_nxt = i_diag_enable ? mfde_pkg::MFDE_SCAN : mfde_pkg::MFDE_DONE;
        end
      end
      mfde_pkg::MFDE_SCAN: begin
        sel_nxt = 1'b0;
        if (half_r) begin
          vld_nxt  = 1'b1;
          addr_nxt = addr_r + 6'h01;
          if (large_r) begin
            data_nxt = {ch_r, stat_r[5:0]};
          end else begin
            data_nxt = stat_r;
          end
          half_nxt = 1'b0;
          cnt_nxt  = cnt_r + 5'h01;
          if (ch_r == 2'(mfde_pkg::CHANNELS - 1)) begin
            ch_nxt  = 2'h0;
            mod_nxt = mod_r + 8'h01;
          end else begin
            ch_nxt = ch_r + 2'h1;
          end
          if (cnt_r + 5'h01 == MAXE ||
              (ch_r == 2'(mfde_pkg::CHANNELS - 1) && mod_r == LAST_MOD)) begin
            state_nxt = mfde_pkg::MFDE_DONE;
          end
        end else if (faulty) begin
          vld_nxt  = 1'b1;
          addr_nxt = 6'(mfde_pkg::FIRST_ENTRY_BYTE) + {cnt_r, 1'b0};
          if (large_r) begin
            data_nxt = mod_r;
          end else begin
            data_nxt = {ch_r, mod_r[5:0]};
          end
          stat_nxt = i_status;
          half_nxt = 1'b1;
        end else begin
          if (ch_r == 2'(mfde_pkg::CHANNELS - 1)) begin
            ch_nxt  = 2'h0;
            mod_nxt = mod_r + 8'h01;
            if (mod_r == LAST_MOD) begin
              state_nxt = mfde_pkg::MFDE_DONE;
            end
          end else begin
            ch_nxt = ch_r + 2'h1;
          end
        end
      end
      mfde_pkg::MFDE_DONE: begin
        done_nxt  = 1'b1;
        state_nxt = mfde_pkg::MFDE_IDLE;
      end
      default: state_nxt = mfde_pkg::MFDE_IDLE;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      state_r <= mfde_pkg::MFDE_IDLE;
      mod_r   <= 8'h00;
      ch_r    <= 2'h0;
      cnt_r   <= 5'h00;
      half_r  <= 1'b0;
      large_r <= 1'b0;
      sel_r   <= 1'b0;
      vld_r   <= 1'b0;
      addr_r  <= 6'h00;
      data_r  <= 8'h00;
      stat_r  <= 8'h00;
      done_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      mod_r   <= mod_nxt;
      ch_r    <= ch_nxt;
      cnt_r   <= cnt_nxt;
      half_r  <= half_nxt;
      large_r <= large_nxt;
      sel_r   <= sel_nxt;
      vld_r   <= vld_nxt;
      addr_r  <= addr_nxt;
      data_r  <= data_nxt;
      stat_r  <= stat_nxt;
      done_r  <= done_nxt;
    end
  end

  assign o_mod_index   = mod_r;
  assign o_chan_index  = ch_r;
  assign o_byte_valid  = vld_r;
  assign o_byte_addr   = addr_r;
  assign o_byte_data   = data_r;
  assign o_entry_count = cnt_r;
  assign o_done        = done_r;

  // checks
  a_no_entry_disabled: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (i_start && state_r == mfde_pkg::MFDE_IDLE && !i_diag_enable)
    |=> ##1 (o_done && !o_byte_valid))
    else $error("entry emitted with diagnosis off");
  a_small_mod_byte: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (state_r == mfde_pkg::MFDE_SCAN && !half_r && faulty && !large_r)
    |=> (o_byte_data == {$past(ch_r), $past(mod_r[5:0])}))
    else $error("small layout module byte wrong");
  a_chan_field: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (state_r == mfde_pkg::MFDE_SCAN && half_r && large_r)
    |=> (o_byte_data[7:6] == $past(ch_r)))
    else $error("channel field wrong");
  a_small_status: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (state_r == mfde_pkg::MFDE_SCAN && half_r && !large_r)
    |=> (o_byte_data == $past(stat_r)))
    else $error("small layout status byte wrong");
  a_large_mod_byte: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (state_r == mfde_pkg::MFDE_SCAN && !half_r && faulty && large_r)
    |=> (o_byte_data == $past(mod_r)))
    else $error("large layout module byte wrong");
  a_large_status: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (state_r == mfde_pkg::MFDE_SCAN && half_r && large_r)
    |=> (o_byte_data[5:0] == $past(stat_r[5:0])))
    else $error("large layout status bits wrong");
  a_fault_detect: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (state_r == mfde_pkg::MFDE_SCAN && !half_r &&
     (i_is_serial ? i_status[mfde_pkg::FAULT_BIT_SERIAL] : i_status[mfde_pkg::FAULT_BIT_STD]))
    |=> (o_byte_valid && half_r))
    else $error("faulty channel not reported");
  a_selector_byte: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (state_r == mfde_pkg::MFDE_IDLE && i_start)
    |=> (o_byte_valid && o_byte_addr == 6'(mfde_pkg::SELECTOR_BYTE) &&
         o_byte_data == (large_r ? mfde_pkg::FMT_LARGE : mfde_pkg::FMT_SMALL)))
    else $error("selector byte wrong");
  a_addr_bound: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (o_byte_valid && !sel_r)
    |-> (o_byte_addr >= 6'(mfde_pkg::FIRST_ENTRY_BYTE) &&
         o_byte_addr <= 6'(mfde_pkg::LAST_ENTRY_BYTE + 1) && o_entry_count <= MAXE))
    else $error("entry outside window");
  a_entry_addr: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (state_r == mfde_pkg::MFDE_SCAN && !half_r && faulty)
    |=> (o_byte_addr == 6'(mfde_pkg::FIRST_ENTRY_BYTE) + {o_entry_count, 1'b0}))
    else $error("entry address not consecutive");
  a_stop_full: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (o_entry_count == MAXE) |-> (state_r != mfde_pkg::MFDE_SCAN))
    else $error("scan continued after full list");
  c_small_entry: cover property (@(posedge i_clock) disable iff (!i_resetn)
    o_byte_valid && !large_r && o_byte_addr == 6'h11);
  c_large_entry: cover property (@(posedge i_clock) disable iff (!i_resetn)
    o_byte_valid && large_r && o_byte_addr == 6'h11);
  c_full_list: cover property (@(posedge i_clock) disable iff (!i_resetn)
    o_byte_valid && o_byte_addr == 6'h3D);
  c_diag_off: cover property (@(posedge i_clock) disable iff (!i_resetn)
    i_start && state_r == mfde_pkg::MFDE_IDLE && !i_diag_enable);
endmodule // mfde_encoder

// >>> bench/mfde_status_src.sv
/*
  mfde_status_src: far-side model of the module channel status source.
  Assumes the encoder drives the indices; answers combinationally.
*/
`timescale 1ns/10ps
module mfde_status_src (
  input  wire logic [7:0] i_mod_index,
  input  wire logic [1:0] i_chan_index,
  input  wire logic [1:0] i_mode,
  output logic      [7:0] o_status,
  output logic            o_is_serial
);
  // mode 1: sparse faults, module 3 serial; mode 2: every channel faulty
  always_comb begin
    o_is_serial = (i_mode == 2'h1) && (i_mod_index == 8'h03);
    o_status    = 8'h00;
    if (i_mode == 2'h2) begin
      o_status = 8'h40;
    end else if (i_mode == 2'h1) begin
      case ({i_mod_index, i_chan_index})
        10'h00B: o_status = 8'h4F;
        10'h00D: o_status = 8'h08;
        10'h00E: o_status = 8'h40;
        10'h014: o_status = 8'h08;
        default: o_status = 8'h00;
      endcase
    end
  end
endmodule // mfde_status_src

// >>> bench/tb.sv
/*
  tb: self-checking bench for mfde_encoder with eight modules.
  Assumes mfde_status_src answers the encoder's indices.
*/
`timescale 1ns/10ps
module tb;
  logic       i_clock        = 1'b0;
  logic       i_resetn       = 1'b0;
  logic       i_start        = 1'b0;
  logic       i_diag_enable  = 1'b0;
  logic       i_large_layout = 1'b0;
  logic [1:0] mode           = 2'h0;
  logic [7:0] status;
  logic       serial;
  logic [7:0] mod_index;
  logic [1:0] chan_index;
  logic       byte_valid;
  logic [5:0] byte_addr;
  logic [7:0] byte_data;
  logic [4:0] entry_count;
  logic       done;
  logic [7:0] mem [64];
  logic [7:0] nwr;
  int         err_count = 0;
  int         compares  = 0;

  always #20 i_clock = ~i_clock;

  mfde_encoder #(.NUM_MODULES(8)) dut_u (
    .i_clock(i_clock), .i_resetn(i_resetn), .i_start(i_start),
    .i_diag_enable(i_diag_enable), .i_large_layout(i_large_layout),
    .i_status(status), .i_is_serial(serial), .o_mod_index(mod_index),
    .o_chan_index(chan_index), .o_byte_valid(byte_valid), .o_byte_addr(byte_addr),
    .o_byte_data(byte_data), .o_entry_count(entry_count), .o_done(done));

  mfde_status_src src_u (.i_mod_index(mod_index), .i_chan_index(chan_index),
    .i_mode(mode), .o_status(status), .o_is_serial(serial));

  // capture every written byte of the message
  always @(negedge i_clock) begin
    if (byte_valid === 1'b1) begin
      mem[byte_addr] = byte_data;
      nwr = nwr + 8'h01;
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic run(input logic en, input logic lg, input logic [1:0] md);
    int n;
    @(negedge i_clock);
    for (n = 0; n < 64; n++) mem[n] = 8'h00;
    nwr = 8'h00;
    i_diag_enable = en;
    i_large_layout = lg;
    mode = md;
    i_start = 1'b1;
    @(negedge i_clock);
    i_start = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 200) begin
      @(negedge i_clock);
      n++;
    end
    if (n >= 200) err_count++;
  endtask

  task automatic t_disabled;
    run(1'b0, 1'b0, 2'h2);
    chk(nwr, 8'h01);
    chk(mem[7], mfde_pkg::FMT_SMALL);
  endtask

  task automatic t_small;
    run(1'b1, 1'b0, 2'h1);
    chk(mem[7], mfde_pkg::FMT_SMALL);
    chk(mem[16], 8'hC2);
    chk(mem[17], 8'h4F);
    chk(mem[18], 8'h43);
    chk(mem[19], 8'h08);
    chk(nwr, 8'h05);
    chk({3'h0, entry_count}, 8'h02);
  endtask

  task automatic t_large;
    run(1'b1, 1'b1, 2'h1);
    chk(mem[7], mfde_pkg::FMT_LARGE);
    chk(mem[16], 8'h02);
    chk(mem[17], 8'hCF);
    chk(mem[18], 8'h03);
    chk(mem[19], 8'h48);
  endtask

  task automatic t_full;
    run(1'b1, 1'b0, 2'h2);
    chk(nwr, 8'h2F);
    chk(mem[60], 8'h85);
    chk(mem[61], 8'h40);
    chk({3'h0, entry_count}, 8'h17);
  endtask

  // reset in mid-scan clears the walk; bench reruns a scan afterwards
  task automatic t_reset;
    @(negedge i_clock);
    i_diag_enable = 1'b1;
    i_large_layout = 1'b0;
    mode = 2'h2;
    i_start = 1'b1;
    @(negedge i_clock);
    i_start = 1'b0;
    repeat (6) @(negedge i_clock);
    i_resetn = 1'b0;
    @(negedge i_clock);
    chk({byte_valid, done, 1'b0, entry_count}, 8'h00);
    chk(byte_data, 8'h00);
    i_resetn = 1'b1;
    repeat (2) @(negedge i_clock);
    chk({byte_valid, done, 1'b0, entry_count}, 8'h00);
  endtask

  task automatic conclude;
    $display("errors=%0d compares=%0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (2) @(negedge i_clock);
    i_resetn = 1'b1;
    t_disabled();
    t_small();
    t_large();
    t_full();
    t_reset();
    t_small();
    conclude();
  end

  initial begin
    #100000;
    err_count++;
    conclude();
  end
endmodule // tb
